// ---- rtl/fbpc_defs.vh ----
// Functional notes
// - program flash is 512 pages of 128 bytes; programmed per byte or page
// - every byte or page program erases its target first by itself
// - each erase-and-program operation takes about 10 ms
// - flash reads return one byte each, with no wait states
// - top 1K bytes form the boot sector holding loader routines
// - boot sector may be erased, freeing the whole 64K to the application
// - external code access pin low disables internal code, fetches go external
// - security byte is FFh after full erase; each bit active low
// - security byte is read or written only by the parallel programmer
// - configuration page lies outside the program memory address space
// - safe lock bit cleared protects the security byte from change
// - boot sector write guard set permits software writes to boot sector
// - boot sector write guard is cleared by default, forbidding software writes
// - guard cleared: software writes to FC00h..FFFFh are ignored
// - guard blocks software writes only; programmer access follows lock level
// - boot entry select set: execution starts at 0000h after reset
// - boot entry select cleared: execution starts at FC03h, the loader
// - parts ship with boot entry select cleared
// - lowest lock bit: block external table reads, latch pin, stop programming
// - second lock level stops verify; third stops external execution
`ifndef FBPC_DEFS_VH
`define FBPC_DEFS_VH
`define FBP_ADDR_W        16
`define FBP_PAGES         512
`define FBP_PAGE_BYTES    128
`define FBP_PAGE_W        7
`define FBP_BOOT_LO       16'hfc00
`define FBP_VEC_APP       16'h0000
`define FBP_VEC_ISP       16'hfc03
`define FBP_SEC_ERASED    8'hff
`define FBP_SEC_FACTORY   8'h18
`define FBP_BYTE_ERASED   8'hff
`define FBP_SB_BIT        7
`define FBP_BOOT_BIT      6
`define FBP_GUARD_BIT     5
`define FBP_LOCK_MSB      2
`define FBP_LOCK_LSB      0
`define FBP_PROG_TIME_US  10000
`define FBP_CLK_MHZ       125
`define FBP_PROG_CYCLES   (`FBP_PROG_TIME_US * `FBP_CLK_MHZ)
`define FBP_CMD_PROG      3'h0
`define FBP_CMD_READ      3'h1
`define FBP_CMD_SEC_WR    3'h2
`define FBP_CMD_SEC_RD    3'h3
`define FBP_CMD_ERASE     3'h4
`define FBP_CMD_XPROG     3'h5
`define FBP_CMD_XREAD     3'h6
`endif

// ---- rtl/fbpc_top.v ----
`timescale 1ns/1ps
`include "fbpc_defs.vh"
module fbpc_top #(
    parameter CNT_W = 21,
    parameter [CNT_W-1:0] PROG_CYCLES = `FBP_PROG_CYCLES
) (
    input  wire        CORE_CLK,
    input  wire        NRST,
    input  wire        CPU_RD,
    input  wire        CPU_TBL_EXT,
    input  wire        CPU_XSEL,
    input  wire [15:0] CPU_ADDR,
    input  wire [7:0]  CPU_WDATA,
    input  wire        CPU_LOAD,
    input  wire        CPU_PROG,
    input  wire        CPU_PAGE,
    input  wire        EXTERNAL_CODE_ACCESS_N,
    input  wire        PP_STB,
    input  wire [2:0]  PP_CMD,
    input  wire [15:0] PP_ADDR,
    input  wire [7:0]  PP_WDATA,
    output reg  [7:0]  CPU_RDATA,
    output reg         CPU_RVALID,
    output reg         CPU_ERR,
    output reg         FLASH_BUSY,
    output reg  [7:0]  PP_RDATA,
    output reg         PP_RVALID,
    output reg         PP_ERR,
    output reg  [15:0] BOOT_ADDR,
    output reg         BOOT_VALID,
    output reg         EXT_FETCH,
    output reg         EXT_EXEC_EN,
    output reg  [7:0]  SEC_BYTE
);
    localparam S_IDLE  = 2'd0;
    localparam S_ERASE = 2'd1;
    localparam S_WAIT  = 2'd2;
    localparam S_WRITE = 2'd3;
    localparam K_BYTE  = 2'd0;
    localparam K_PAGE  = 2'd1;
    localparam K_CHIP  = 2'd2;
    localparam MEM_SIZE = `FBP_PAGES * `FBP_PAGE_BYTES;

    // nonvolatile storage: no reset, survives NRST
    reg  [7:0]             mem [0:MEM_SIZE-1];
    reg  [7:0]             extra_config_page [0:`FBP_PAGE_BYTES-1];
    reg  [7:0]             pbuf [0:`FBP_PAGE_BYTES-1];
    reg  [7:0]             sec;
    reg  [`FBP_PAGE_BYTES-1:0] mask_reg;
    reg  [`FBP_PAGE_BYTES-1:0] mask_next;
    reg  [1:0]             state_reg;
    reg  [1:0]             state_next;
    reg  [1:0]             kind_reg;
    reg  [1:0]             kind_next;
    reg                    jx_reg;
    reg                    jx_next;
    reg  [15:0]            base_reg;
    reg  [15:0]            base_next;
    reg  [7:0]             jd_reg;
    reg  [7:0]             jd_next;
    reg  [15:0]            idx_reg;
    reg  [15:0]            idx_next;
    reg  [CNT_W-1:0]       cnt_reg;
    reg  [CNT_W-1:0]       cnt_next;
    reg  [1:0]             init_reg;
    reg                    ea_latch_reg;
    reg                    ea_s1_reg;
    reg                    ea_s2_reg;
    reg  [2:0]             stb_s_reg;
    reg  [2:0]             cmd_s1_reg;
    reg  [2:0]             cmd_s2_reg;
    reg  [15:0]            pa_s1_reg;
    reg  [15:0]            pa_s2_reg;
    reg  [7:0]             pd_s1_reg;
    reg  [7:0]             pd_s2_reg;
    reg                    mem_we;
    reg                    xaf_we;
    reg  [7:0]             wd;
    reg                    sec_we;
    reg  [7:0]             sec_wd;
    reg                    cpu_err_next;
    reg                    pp_err_next;
    reg                    pp_rv_next;
    reg  [7:0]             pp_rd_next;

    wire [2:0]  lock = sec[`FBP_LOCK_MSB:`FBP_LOCK_LSB];
    wire        lvl2 = ~&lock;
    wire        lvl3 = ~lock[1] | ~lock[2];
    wire        lvl4 = ~lock[2];
    wire        idle = (state_reg == S_IDLE);
    wire        pp_ev = stb_s_reg[1] & ~stb_s_reg[2];
    wire        in_boot = (CPU_ADDR >= `FBP_BOOT_LO);
    // software guard only; programmer path never consults it
    wire        guard_hit = ~CPU_XSEL & in_boot & ~sec[`FBP_GUARD_BIT];
    wire        cpu_ok = CPU_PROG & idle & ~guard_hit;
    wire        ea_eff = lvl2 ? ea_latch_reg : ea_s2_reg;
    wire [15:0] last = (kind_reg == K_CHIP) ? 16'hffff :
                       (kind_reg == K_PAGE) ? 16'h007f : 16'h0000;
    wire [15:0] tgt = (kind_reg == K_CHIP) ? idx_reg :
                      (kind_reg == K_PAGE) ?
                      {base_reg[15:`FBP_PAGE_W], idx_reg[`FBP_PAGE_W-1:0]} : base_reg;
    wire [6:0]  pi = idx_reg[6:0];

    always @*
    begin
        state_next   = state_reg;
        kind_next    = kind_reg;
        jx_next      = jx_reg;
        base_next    = base_reg;
        jd_next      = jd_reg;
        idx_next     = idx_reg;
        cnt_next     = cnt_reg;
        mask_next    = mask_reg;
        mem_we       = 1'b0;
        xaf_we       = 1'b0;
        wd           = `FBP_BYTE_ERASED;
        sec_we       = 1'b0;
        sec_wd       = `FBP_SEC_ERASED;
        cpu_err_next = CPU_PROG & ~cpu_ok;
        pp_err_next  = 1'b0;
        pp_rv_next   = 1'b0;
        pp_rd_next   = PP_RDATA;
        if (CPU_LOAD)
        begin
            mask_next[CPU_ADDR[6:0]] = 1'b1;
        end
        case (state_reg)
            S_IDLE:
            begin
                if (cpu_ok)
                begin
                    kind_next  = CPU_PAGE ? K_PAGE : K_BYTE;
                    jx_next    = CPU_XSEL;
                    base_next  = CPU_ADDR;
                    jd_next    = CPU_WDATA;
                    idx_next   = 16'h0000;
                    state_next = S_ERASE;
                end
            end
            S_ERASE:
            begin
                // erase sweeps one byte a cycle; whole chip takes 64K cycles
                if (kind_reg == K_CHIP)
                begin
                    mem_we = 1'b1;
                    xaf_we = (idx_reg[15:7] == 9'h000);
                    if (idx_reg == 16'h0000)
                    begin
                        sec_we = 1'b1;
                    end
                end
                else
                begin
                    mem_we = ~jx_reg;
                    xaf_we = jx_reg;
                end
                if (idx_reg == last)
                begin
                    idx_next   = 16'h0000;
                    cnt_next   = {CNT_W{1'b0}};
                    state_next = S_WAIT;
                end
                else
                begin
                    idx_next = idx_reg + 16'h0001;
                end
            end
            S_WAIT:
            begin
                if (cnt_reg == PROG_CYCLES - 1'b1)
                begin
                    state_next = (kind_reg == K_CHIP) ? S_IDLE : S_WRITE;
                    if (kind_reg == K_CHIP)
                    begin
                        mask_next = {`FBP_PAGE_BYTES{1'b0}};
                    end
                end
                else
                begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            S_WRITE:
            begin
                mem_we = ~jx_reg;
                xaf_we = jx_reg;
                if (kind_reg == K_PAGE)
                begin
                    // bytes never loaded stay erased
                    wd = mask_reg[pi] ? pbuf[pi] : `FBP_BYTE_ERASED;
                end
                else
                begin
                    wd = jd_reg;
                end
                if (idx_reg == last)
                begin
                    state_next = S_IDLE;
                    if (kind_reg == K_PAGE)
                    begin
                        mask_next = {`FBP_PAGE_BYTES{1'b0}};
                    end
                end
                else
                begin
                    idx_next = idx_reg + 16'h0001;
                end
            end
            default:
            begin
                state_next = S_IDLE;
            end
        endcase
        if (pp_ev)
        begin
            case (cmd_s2_reg)
                `FBP_CMD_PROG,
                `FBP_CMD_XPROG:
                begin
                    if (idle & ~cpu_ok & ~lvl2)
                    begin
                        kind_next  = K_BYTE;
                        jx_next    = (cmd_s2_reg == `FBP_CMD_XPROG);
                        base_next  = pa_s2_reg;
                        jd_next    = pd_s2_reg;
                        idx_next   = 16'h0000;
                        state_next = S_ERASE;
                    end
                    else
                    begin
                        pp_err_next = 1'b1;
                    end
                end
                `FBP_CMD_ERASE:
                begin
                    // chip erase ignores the lock bits and runs whenever the engine is idle and no CPU program starts: it is the way out of any lock
                    if (idle & ~cpu_ok)
                    begin
                        kind_next  = K_CHIP;
                        idx_next   = 16'h0000;
                        state_next = S_ERASE;
                    end
                    else
                    begin
                        pp_err_next = 1'b1;
                    end
                end
                `FBP_CMD_SEC_WR:
                begin
                    if (sec[`FBP_SB_BIT] & idle)
                    begin
                        sec_we = 1'b1;
                        sec_wd = pd_s2_reg;
                    end
                    else
                    begin
                        pp_err_next = 1'b1;
                    end
                end
                `FBP_CMD_SEC_RD:
                begin
                    pp_rv_next = 1'b1;
                    pp_rd_next = sec;
                end
                `FBP_CMD_READ,
                `FBP_CMD_XREAD:
                begin
                    pp_rv_next  = 1'b1;
                    pp_err_next = lvl3;
                    if (lvl3)
                    begin
                        pp_rd_next = `FBP_BYTE_ERASED;
                    end
                    else if (cmd_s2_reg == `FBP_CMD_XREAD)
                    begin
                        pp_rd_next = extra_config_page[pa_s2_reg[6:0]];
                    end
                    else
                    begin
                        pp_rd_next = mem[pa_s2_reg];
                    end
                end
                default:
                begin
                    pp_err_next = 1'b1;
                end
            endcase
        end
    end

    initial
    begin
        sec = `FBP_SEC_FACTORY;
    end

    always @(posedge CORE_CLK)
    begin
        if (mem_we)
        begin
            mem[tgt] <= wd;
        end
        if (xaf_we)
        begin
            extra_config_page[tgt[6:0]] <= wd;
        end
        if (sec_we)
        begin
            sec <= sec_wd;
        end
        if (CPU_LOAD)
        begin
            pbuf[CPU_ADDR[6:0]] <= CPU_WDATA;
        end
    end

    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_reg    <= S_IDLE;
            kind_reg     <= K_BYTE;
            jx_reg       <= 1'b0;
            base_reg     <= 16'h0000;
            jd_reg       <= 8'h00;
            idx_reg      <= 16'h0000;
            cnt_reg      <= {CNT_W{1'b0}};
            mask_reg     <= {`FBP_PAGE_BYTES{1'b0}};
            init_reg     <= 2'd0;
            ea_latch_reg <= 1'b1;
            ea_s1_reg    <= 1'b1;
            ea_s2_reg    <= 1'b1;
            stb_s_reg    <= 3'h0;
            cmd_s1_reg   <= 3'h0;
            cmd_s2_reg   <= 3'h0;
            pa_s1_reg    <= 16'h0000;
            pa_s2_reg    <= 16'h0000;
            pd_s1_reg    <= 8'h00;
            pd_s2_reg    <= 8'h00;
            CPU_RDATA    <= 8'h00;
            CPU_RVALID   <= 1'b0;
            CPU_ERR      <= 1'b0;
            FLASH_BUSY   <= 1'b0;
            PP_RDATA     <= 8'h00;
            PP_RVALID    <= 1'b0;
            PP_ERR       <= 1'b0;
            BOOT_ADDR    <= `FBP_VEC_APP;
            BOOT_VALID   <= 1'b0;
            EXT_FETCH    <= 1'b0;
            EXT_EXEC_EN  <= 1'b0;
            SEC_BYTE     <= 8'h00;
        end
        else
        begin
            state_reg  <= state_next;
            kind_reg   <= kind_next;
            jx_reg     <= jx_next;
            base_reg   <= base_next;
            jd_reg     <= jd_next;
            idx_reg    <= idx_next;
            cnt_reg    <= cnt_next;
            mask_reg   <= mask_next;
            ea_s1_reg  <= EXTERNAL_CODE_ACCESS_N;
            ea_s2_reg  <= ea_s1_reg;
            stb_s_reg  <= {stb_s_reg[1:0], PP_STB};
            cmd_s1_reg <= PP_CMD;
            cmd_s2_reg <= cmd_s1_reg;
            pa_s1_reg  <= PP_ADDR;
            pa_s2_reg  <= pa_s1_reg;
            pd_s1_reg  <= PP_WDATA;
            pd_s2_reg  <= pd_s1_reg;
            // wait for the pin synchroniser to fill before latching
            if (init_reg != 2'd3)
            begin
                init_reg <= init_reg + 2'd1;
            end
            if (init_reg == 2'd2)
            begin
                ea_latch_reg <= ea_s2_reg;
                BOOT_VALID   <= 1'b1;
                BOOT_ADDR    <= sec[`FBP_BOOT_BIT] ? `FBP_VEC_APP : `FBP_VEC_ISP;
            end
            // single-cycle read path, fixed latency, never stretched
            CPU_RVALID <= CPU_RD;
            if (CPU_RD)
            begin
                if (CPU_TBL_EXT & lvl2)
                begin
                    CPU_RDATA <= `FBP_BYTE_ERASED;
                end
                else if (CPU_XSEL)
                begin
                    CPU_RDATA <= extra_config_page[CPU_ADDR[6:0]];
                end
                else
                begin
                    CPU_RDATA <= mem[CPU_ADDR];
                end
            end
            CPU_ERR     <= cpu_err_next;
            FLASH_BUSY  <= (state_next != S_IDLE);
            PP_RDATA    <= pp_rd_next;
            PP_RVALID   <= pp_rv_next;
            PP_ERR      <= pp_err_next;
            EXT_FETCH   <= BOOT_VALID & ~ea_eff;
            EXT_EXEC_EN <= BOOT_VALID & ~lvl4;
            SEC_BYTE    <= sec;
        end
    end
endmodule // fbpc_top

// ---- sim/fbpc_chk.sv ----
`timescale 1ns/1ps
module fbpc_chk #(
    parameter CNT_W = 21,
    parameter [CNT_W-1:0] PROG_CYCLES = 16
) (
    input wire        CORE_CLK,
    input wire        NRST,
    input wire        CPU_RD,
    input wire        CPU_PROG,
    input wire        CPU_XSEL,
    input wire [15:0] CPU_ADDR,
    input wire [7:0]  CPU_RDATA,
    input wire        CPU_RVALID,
    input wire        CPU_ERR,
    input wire        FLASH_BUSY,
    input wire        PP_RVALID,
    input wire [15:0] BOOT_ADDR,
    input wire        BOOT_VALID,
    input wire        EXT_EXEC_EN,
    input wire [7:0]  SEC_BYTE
);
    reg [31:0] busy_cnt_reg;
    // erase jobs run long; only program jobs are timed
    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= FLASH_BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    rd_answer_a: assert property (CPU_RD |=> CPU_RVALID) else $error("read not answered");
    rd_spurious_a: assert property (!CPU_RD |=> !CPU_RVALID) else $error("stray read valid");
    rdata_hold_a: assert property (!CPU_RVALID |-> $stable(CPU_RDATA)) else $error("rdata moved");
    boot_vec_a: assert property ($rose(BOOT_VALID) |->
        BOOT_ADDR == (SEC_BYTE[6] ? 16'h0000 : 16'hfc03)) else $error("bad boot vector");
    boot_hold_a: assert property (BOOT_VALID |=> BOOT_VALID) else $error("boot valid fell");
    exec_lock_a: assert property ($rose(BOOT_VALID) |=> EXT_EXEC_EN == SEC_BYTE[2])
        else $error("external execution enable wrong");
    guard_block_a: assert property (CPU_PROG && !CPU_XSEL && CPU_ADDR >= 16'hfc00 && !SEC_BYTE[5]
        |=> CPU_ERR && !FLASH_BUSY) else $error("guarded write taken");
    guard_open_a: assert property (CPU_PROG && !FLASH_BUSY && !$past(CPU_PROG) && SEC_BYTE[5]
        |=> FLASH_BUSY && !CPU_ERR) else $error("open write refused");
    prog_time_a: assert property ($fell(FLASH_BUSY) && busy_cnt_reg < 32'd1000 |->
        busy_cnt_reg == PROG_CYCLES + 32'd2 || busy_cnt_reg == PROG_CYCLES + 32'd256)
        else $error("program time wrong");
    pp_pulse_a: assert property (PP_RVALID |=> !PP_RVALID) else $error("pp valid too long");
    refuse_c: cover property (CPU_ERR);
    done_c: cover property ($fell(FLASH_BUSY));
    pp_read_c: cover property (PP_RVALID);
endmodule // fbpc_chk
bind fbpc_top fbpc_chk #(.CNT_W(CNT_W), .PROG_CYCLES(PROG_CYCLES)) u_chk (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .CPU_RD(CPU_RD), .CPU_PROG(CPU_PROG),
    .CPU_XSEL(CPU_XSEL), .CPU_ADDR(CPU_ADDR), .CPU_RDATA(CPU_RDATA),
    .CPU_RVALID(CPU_RVALID), .CPU_ERR(CPU_ERR), .FLASH_BUSY(FLASH_BUSY),
    .PP_RVALID(PP_RVALID), .BOOT_ADDR(BOOT_ADDR), .BOOT_VALID(BOOT_VALID),
    .EXT_EXEC_EN(EXT_EXEC_EN), .SEC_BYTE(SEC_BYTE));

// ---- sim/fbpc_pp_model.sv ----
`timescale 1ns/1ps
`include "fbpc_defs.vh"
module fbpc_pp_model (
    input  wire        core_clk,
    input  wire [7:0]  pp_rdata,
    input  wire        pp_rvalid,
    input  wire        pp_err,
    input  wire        flash_busy,
    output reg         pp_stb,
    output reg  [2:0]  pp_cmd,
    output reg  [15:0] pp_addr,
    output reg  [7:0]  pp_wdata
);
    initial
    begin
        pp_stb = 1'b0;
        pp_cmd = 3'h7;
        pp_addr = 16'h0;
        pp_wdata = 8'h0;
    end
    // one strobed command; pins settle 4 clocks before the strobe edge
    task op(input [2:0] c, input [15:0] a, input [7:0] d, output e, output [7:0] r);
        integer i;
        begin
            e = 1'b0;
            r = 8'h00;
            @(posedge core_clk);
            #1;
            pp_cmd = c;
            pp_addr = a;
            pp_wdata = (c == `FBP_CMD_SEC_WR) ? (d | 8'h18) : d;
            repeat (4) @(posedge core_clk);
            #1;
            pp_stb = 1'b1;
            for (i = 0; i < 8; i = i + 1)
            begin
                @(posedge core_clk);
                #1;
                if (pp_err === 1'b1) e = 1'b1;
                if (pp_rvalid === 1'b1) r = pp_rdata;
            end
            // hold time over: released lines no longer show the old value
            pp_cmd = ~pp_cmd;
            pp_addr = ~pp_addr;
            pp_wdata = ~pp_wdata;
            pp_stb = 1'b0;
            i = 0;
            while (flash_busy === 1'b1 && i < 70000)
            begin
                @(posedge core_clk);
                i = i + 1;
            end
            repeat (4) @(posedge core_clk);
            #1;
        end
    endtask
endmodule // fbpc_pp_model

// ---- sim/fbpc_top_tb.sv ----
`timescale 1ns/1ps
`include "fbpc_defs.vh"
module fbpc_top_tb;
    localparam PC = 16;
    reg CORE_CLK = 0, NRST = 0, CPU_RD = 0, CPU_TBL_EXT = 0, CPU_XSEL = 0;
    reg CPU_LOAD = 0, CPU_PROG = 0, CPU_PAGE = 0, EXT_N = 1;
    reg [15:0] CPU_ADDR = 16'h0;
    reg [7:0] CPU_WDATA = 8'h0;
    wire PP_STB, CPU_RVALID, CPU_ERR, FLASH_BUSY, PP_RVALID, PP_ERR, BOOT_VALID;
    wire EXT_FETCH, EXT_EXEC_EN;
    wire [2:0] PP_CMD;
    wire [15:0] PP_ADDR, BOOT_ADDR;
    wire [7:0] PP_WDATA, CPU_RDATA, PP_RDATA, SEC_BYTE;
    integer n_mismatch = 0, check_count = 0, cyc = 0, n;
    reg e;
    reg [7:0] r;
    always #4 CORE_CLK = ~CORE_CLK;
    fbpc_top #(.CNT_W(21), .PROG_CYCLES(21'd16)) uut (
        .CORE_CLK(CORE_CLK), .NRST(NRST), .CPU_RD(CPU_RD), .CPU_TBL_EXT(CPU_TBL_EXT),
        .CPU_XSEL(CPU_XSEL), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
        .CPU_LOAD(CPU_LOAD), .CPU_PROG(CPU_PROG), .CPU_PAGE(CPU_PAGE),
        .EXTERNAL_CODE_ACCESS_N(EXT_N), .PP_STB(PP_STB), .PP_CMD(PP_CMD),
        .PP_ADDR(PP_ADDR), .PP_WDATA(PP_WDATA), .CPU_RDATA(CPU_RDATA),
        .CPU_RVALID(CPU_RVALID), .CPU_ERR(CPU_ERR), .FLASH_BUSY(FLASH_BUSY),
        .PP_RDATA(PP_RDATA), .PP_RVALID(PP_RVALID), .PP_ERR(PP_ERR),
        .BOOT_ADDR(BOOT_ADDR), .BOOT_VALID(BOOT_VALID), .EXT_FETCH(EXT_FETCH),
        .EXT_EXEC_EN(EXT_EXEC_EN), .SEC_BYTE(SEC_BYTE));
    fbpc_pp_model pp (.core_clk(CORE_CLK), .pp_rdata(PP_RDATA), .pp_rvalid(PP_RVALID),
        .pp_err(PP_ERR), .flash_busy(FLASH_BUSY), .pp_stb(PP_STB), .pp_cmd(PP_CMD),
        .pp_addr(PP_ADDR), .pp_wdata(PP_WDATA));
    task tick;
        begin
            @(posedge CORE_CLK);
            #1;
        end
    endtask
    task chk(input string name, input [15:0] exp, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task summarize;
        begin
            $display("mismatches %0d checks %0d", n_mismatch, check_count);
            if (n_mismatch == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task do_reset;
        begin
            NRST = 0;
            repeat (5) tick;
            NRST = 1;
            repeat (4) tick;
        end
    endtask
    task cpu_rd(input [15:0] a, input x, input t, input [7:0] exp);
        begin
            CPU_ADDR = a;
            CPU_XSEL = x;
            CPU_TBL_EXT = t;
            CPU_RD = 1;
            tick;
            CPU_RD = 0;
            CPU_XSEL = 0;
            CPU_TBL_EXT = 0;
            chk("cpu_rvalid", 1, CPU_RVALID);
            chk("cpu_rdata", exp, CPU_RDATA);
            tick;
        end
    endtask
    task cpu_load(input [15:0] a, input [7:0] d);
        begin
            CPU_ADDR = a;
            CPU_WDATA = d;
            CPU_LOAD = 1;
            tick;
            CPU_LOAD = 0;
            tick;
        end
    endtask
    // optional second pulse lands while the engine is busy and must bounce
    task cpu_prog(input [15:0] a, input x, pg, input [7:0] d, input ex, dbl);
        begin
            n = 0;
            CPU_ADDR = a;
            CPU_XSEL = x;
            CPU_PAGE = pg;
            CPU_WDATA = d;
            CPU_PROG = 1;
            tick;
            CPU_PROG = 0;
            CPU_XSEL = 0;
            CPU_PAGE = 0;
            chk("cpu_err", ex, CPU_ERR);
            if (dbl)
            begin
                tick;
                CPU_PROG = 1;
                tick;
                CPU_PROG = 0;
                n = 2;
                chk("busy_err", 1, CPU_ERR);
            end
            // n counts the cycles busy is seen high
            while (FLASH_BUSY === 1'b1 && n < 70000)
            begin
                n = n + 1;
                tick;
            end
            tick;
        end
    endtask
    always @(posedge CORE_CLK)
    begin
        cyc = cyc + 1;
        if (cyc == 90000)
        begin
            n_mismatch = n_mismatch + 1;
            summarize;
        end
    end
    initial
    begin
        do_reset;
        chk("boot_valid", 1, BOOT_VALID);
        chk("boot_addr", 16'hfc03, BOOT_ADDR);
        chk("sec_byte", 8'h18, SEC_BYTE);
        chk("exec_en", 0, EXT_EXEC_EN);
        chk("ext_fetch", 0, EXT_FETCH);
        pp.op(`FBP_CMD_READ, 16'h1234, 8'h00, e, r);
        chk("pp_err", 1, e);
        chk("pp_rdata", 8'hff, r);
        pp.op(`FBP_CMD_PROG, 16'h0100, 8'h55, e, r);
        chk("pp_err", 1, e);
        pp.op(`FBP_CMD_SEC_WR, 16'h0, 8'hff, e, r);
        chk("pp_err", 1, e);
        pp.op(`FBP_CMD_ERASE, 16'h0, 8'h00, e, r);
        pp.op(`FBP_CMD_SEC_RD, 16'h0, 8'h00, e, r);
        chk("pp_sec", 8'hff, r);
        chk("pp_err", 0, e);
        cpu_rd(16'hfc00, 0, 0, 8'hff);
        cpu_prog(16'h1234, 0, 0, 8'h0f, 0, 1);
        chk("byte_busy", PC + 2, n);
        cpu_prog(16'h1234, 0, 0, 8'hf0, 0, 0);
        cpu_rd(16'h1234, 0, 0, 8'hf0);
        cpu_prog(16'hfc20, 0, 0, 8'h11, 0, 0);
        cpu_rd(16'hfc20, 0, 0, 8'h11);
        cpu_prog(16'h0005, 1, 0, 8'h77, 0, 0);
        cpu_rd(16'h0005, 1, 0, 8'h77);
        cpu_rd(16'h0005, 0, 0, 8'hff);
        cpu_load(16'h0200, 8'ha0);
        cpu_load(16'h027f, 8'ha7);
        cpu_prog(16'h0200, 0, 1, 8'h00, 0, 0);
        chk("page_busy", PC + 256, n);
        cpu_rd(16'h0200, 0, 0, 8'ha0);
        cpu_rd(16'h027f, 0, 0, 8'ha7);
        cpu_rd(16'h0201, 0, 0, 8'hff);
        pp.op(`FBP_CMD_SEC_WR, 16'h0, 8'hdf, e, r);
        chk("sec_byte", 8'hdf, SEC_BYTE);
        cpu_prog(16'hfc10, 0, 0, 8'h22, 1, 0);
        cpu_rd(16'hfc10, 0, 0, 8'hff);
        pp.op(`FBP_CMD_PROG, 16'hfc10, 8'h33, e, r);
        chk("pp_err", 0, e);
        cpu_rd(16'hfc10, 0, 0, 8'h33);
        pp.op(`FBP_CMD_SEC_WR, 16'h0, 8'hde, e, r);
        do_reset;
        chk("exec_en", 1, EXT_EXEC_EN);
        pp.op(`FBP_CMD_PROG, 16'h0100, 8'h55, e, r);
        chk("pp_err", 1, e);
        cpu_rd(16'h1234, 0, 1, 8'hff);
        cpu_rd(16'h1234, 0, 0, 8'hf0);
        pp.op(`FBP_CMD_READ, 16'h1234, 8'h00, e, r);
        chk("pp_rdata", 8'hf0, r);
        pp.op(`FBP_CMD_SEC_WR, 16'h0, 8'hdc, e, r);
        pp.op(`FBP_CMD_READ, 16'h1234, 8'h00, e, r);
        chk("pp_err", 1, e);
        pp.op(`FBP_CMD_SEC_WR, 16'h0, 8'h58, e, r);
        pp.op(`FBP_CMD_SEC_WR, 16'h0, 8'hff, e, r);
        chk("pp_err", 1, e);
        chk("sec_byte", 8'h58, SEC_BYTE);
        EXT_N = 0;
        do_reset;
        chk("boot_addr", 16'h0000, BOOT_ADDR);
        chk("exec_en", 0, EXT_EXEC_EN);
        chk("ext_fetch", 1, EXT_FETCH);
        summarize;
    end
endmodule // fbpc_top_tb
